// ---- src/mba_regs.svh ----
// Purpose: constants for the masked burst address counter
// Assumes: included by bare name from the package and the design files
// Notes: definitions only; the register widths are fixed at elaboration
`ifndef MBA_REGS_SVH
`define MBA_REGS_SVH

// address width of the base variant
`define MBA_ADDR_W_DEFAULT 17
// narrowest and widest address widths the logic serves
`define MBA_ADDR_W_MIN 16
`define MBA_ADDR_W_MAX 18
// readback drives the address lines this many edges after the request
`define MBA_READBACK_LAT 1
// reset value of the wrap flag (released, high)
`define MBA_WRAP_RST 1'h1
// reset value of the address line enable (not driving)
`define MBA_OE_RST 1'h0

`endif

// ---- src/mba_pkg.sv ----
// Purpose: types shared by the masked burst address counter files
// Assumes: constants live in mba_regs.svh
// Notes: control inputs travel together as one packed struct
`include "mba_regs.svh"

package mba_pkg;

  // port control inputs, sampled on the rising clock edge
  typedef struct packed {
    logic counter_or_mask_select; // high selects counter, low selects mask
    logic counter_clear_n;        // low clears counter or resets mask
    logic address_strobe_n;       // low with enable selects load or readback
    logic count_enable_n;         // low enables load or increment
  } mba_ctrl_t;

  // decoded operation of one clock cycle
  typedef enum logic [3:0] {
    MBA_OP_CNT_CLEAR,
    MBA_OP_CNT_LOAD,
    MBA_OP_CNT_READ,
    MBA_OP_CNT_INC,
    MBA_OP_CNT_HOLD,
    MBA_OP_MSK_CLEAR,
    MBA_OP_MSK_LOAD,
    MBA_OP_MSK_READ,
    MBA_OP_RESERVED
  } mba_op_t;

endpackage

// ---- src/mba_masked_incr.sv ----
// Purpose: next counter value for an increment under a mask
// Assumes: mask holds a permitted value (ones low, optional zero at bit 0)
// Notes: purely combinational; below the top masked bits pass through untouched, at the top every bit comes from mirror
`timescale 1ns/1ps
`include "mba_regs.svh"

module mba_masked_incr #(
  parameter int ADDR_W = `MBA_ADDR_W_DEFAULT
) (
  // present register values
  input wire logic [ADDR_W-1:0] count,
  input wire logic [ADDR_W-1:0] mask,
  input wire logic [ADDR_W-1:0] mirror,
  // result
  output logic [ADDR_W-1:0] next_count,
  output logic at_top
);

  // masked bits forced to one so the carry ripples straight across them
  logic [ADDR_W-1:0] filled;
  // filled value plus one; a masked bit 0 turns the step into two
  logic [ADDR_W-1:0] bumped;

  // carry trick: one adder serves both step sizes
  always_comb begin
    filled = count | ~mask;
    bumped = filled + ADDR_W'(1);
    at_top = &filled;
    // R4: wrap to mirror
    if (at_top) begin
      next_count = mirror;
    end else begin
      // R1: only unmasked change
      next_count = (bumped & mask) | (count & ~mask);
    end
  end

endmodule // mba_masked_incr

// ---- src/mba_counter.sv ----
// Purpose: one port's burst address counter with mask and mirror registers
// Assumes: control inputs are synchronous to clk_sys; master_reset_n is async
// Notes: address lines are a two-way bus split into in, out and enable
`timescale 1ns/1ps
`include "mba_regs.svh"

// Summary of operation
// R1: increment changes only bits whose mask is one
// R2: step one if mask bit0 set, else two
// R3: flag low when increment leaves unmasked ones
// R4: next increment after top reloads from mirror
// R5: flag high when increment leaves some zero
// R6: clears, loads and master reset release flag
// R7: hold keeps all three registers unchanged
// R8: outside may tie flag to counter clear
// R9: register width parameterised, sixteen to eighteen bits
// R10: all-ones mask counts through whole space
// R11: mask 3F, start 8 counts up, returns
// R12: mirror keeps start address across wraps
// R13: counter select decodes load, readback, increment, hold
// R14: mask select decodes reset, load, readback, reserved
// R15: counter clear zeroes unmasked counter, mirror bits
// R16: master reset async; counter zero, mask ones
// R17: counter load writes counter and mirror together
module mba_counter #(
  parameter int ADDR_W = `MBA_ADDR_W_DEFAULT
) (
  // clock and resets
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic master_reset_n,
  // control strobes from the memory controller
  input wire mba_pkg::mba_ctrl_t ctrl,
  // two-way address lines
  input wire logic [ADDR_W-1:0] addr_i,
  output logic [ADDR_W-1:0] addr_o,
  output logic addr_oe,
  // address toward the memory array
  output logic [ADDR_W-1:0] count_addr,
  // wrap flag, low after an increment leaves the unmasked part all ones
  output logic wrap_flag_n
);

  // R9: width range check
  if (ADDR_W < `MBA_ADDR_W_MIN || ADDR_W > `MBA_ADDR_W_MAX) begin : g_bad_width
    $error("mba_counter: ADDR_W outside the served range");
  end

  // counter register, drives the array address
  logic [ADDR_W-1:0] cnt_q;
  // mask register, ones mark bits that count
  logic [ADDR_W-1:0] mask_q;
  // mirror register, start address for retransmit
  logic [ADDR_W-1:0] mirror_q;
  // wrap flag, active low
  logic wrap_q;
  // readback value and its enable
  logic [ADDR_W-1:0] rb_q;
  logic rb_oe_q;
  // decoded operation of this cycle
  mba_pkg::mba_op_t op;
  // incrementer result
  logic [ADDR_W-1:0] inc_next;
  logic inc_at_top;

  // true when every unmasked bit of a value is one
  function automatic logic unmasked_full(input logic [ADDR_W-1:0] v,
                                         input logic [ADDR_W-1:0] m);
    unmasked_full = &(v | ~m);
  endfunction

  // control decode; select high picks counter operations
  function automatic mba_pkg::mba_op_t decode(input mba_pkg::mba_ctrl_t c);
    mba_pkg::mba_op_t r;
    r = mba_pkg::MBA_OP_RESERVED;
    if (c.counter_or_mask_select) begin
      if (!c.counter_clear_n) begin
        r = mba_pkg::MBA_OP_CNT_CLEAR;
      end else if (!c.address_strobe_n) begin
        r = c.count_enable_n ? mba_pkg::MBA_OP_CNT_READ : mba_pkg::MBA_OP_CNT_LOAD;
      end else begin
        r = c.count_enable_n ? mba_pkg::MBA_OP_CNT_HOLD : mba_pkg::MBA_OP_CNT_INC;
      end
    end else begin
      if (!c.counter_clear_n) begin
        r = mba_pkg::MBA_OP_MSK_CLEAR;
      end else if (!c.address_strobe_n) begin
        r = c.count_enable_n ? mba_pkg::MBA_OP_MSK_READ : mba_pkg::MBA_OP_MSK_LOAD;
      end else begin
        // strobe high under mask select is undefined; treated as no change
        r = mba_pkg::MBA_OP_RESERVED;
      end
    end
    return r;
  endfunction

  // R13: counter select decode
  // R14: mask select decode
  always_comb begin
    op = decode(ctrl);
  end

  // masked step and wrap selection
  mba_masked_incr #(
    .ADDR_W(ADDR_W)
  ) mba_masked_incr_i (
    .count(cnt_q),
    .mask(mask_q),
    .mirror(mirror_q),
    .next_count(inc_next),
    .at_top(inc_at_top)
  );

  // counter register
  always_ff @(posedge clk_sys or negedge master_reset_n) begin
    // R16: async master clear
    if (!master_reset_n) begin
      cnt_q <= '0;
    end else if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      unique case (op)
        // R15: clear unmasked bits
        mba_pkg::MBA_OP_CNT_CLEAR: cnt_q <= cnt_q & ~mask_q;
        // R17: load counter
        mba_pkg::MBA_OP_CNT_LOAD: cnt_q <= addr_i;
        // R2: step one or two
        // R10: full mask spans all
        mba_pkg::MBA_OP_CNT_INC: cnt_q <= inc_next;
        // R7: hold keeps value
        default: cnt_q <= cnt_q;
      endcase
    end
  end

  // mirror register; increments never touch it, so wraps replay the block
  always_ff @(posedge clk_sys or negedge master_reset_n) begin
    if (!master_reset_n) begin
      mirror_q <= '0;
    end else if (!rst_n) begin
      mirror_q <= '0;
    end else begin
      unique case (op)
        // R15: clear unmasked bits
        mba_pkg::MBA_OP_CNT_CLEAR: mirror_q <= mirror_q & ~mask_q;
        // R17: load mirror too
        mba_pkg::MBA_OP_CNT_LOAD: mirror_q <= addr_i;
        // R12: mirror kept
        default: mirror_q <= mirror_q;
      endcase
    end
  end

  // mask register; an unpermitted value is stored but counts oddly
  always_ff @(posedge clk_sys or negedge master_reset_n) begin
    // R16: mask to ones
    if (!master_reset_n) begin
      mask_q <= '1;
    end else if (!rst_n) begin
      mask_q <= '1;
    end else begin
      unique case (op)
        // R14: mask reset, load
        mba_pkg::MBA_OP_MSK_CLEAR: mask_q <= '1;
        mba_pkg::MBA_OP_MSK_LOAD: mask_q <= addr_i;
        default: mask_q <= mask_q;
      endcase
    end
  end

  // wrap flag; judged on the value an increment produces
  always_ff @(posedge clk_sys or negedge master_reset_n) begin
    if (!master_reset_n) begin
      wrap_q <= `MBA_WRAP_RST;
    end else if (!rst_n) begin
      wrap_q <= `MBA_WRAP_RST;
    end else begin
      unique case (op)
        // R3: low at top
        // R5: high otherwise
        // R11: top then back
        mba_pkg::MBA_OP_CNT_INC: wrap_q <= !unmasked_full(inc_next, mask_q);
        // R6: release on clear/load
        mba_pkg::MBA_OP_CNT_CLEAR, mba_pkg::MBA_OP_CNT_LOAD,
        mba_pkg::MBA_OP_MSK_CLEAR, mba_pkg::MBA_OP_MSK_LOAD: wrap_q <= 1'h1;
        default: wrap_q <= wrap_q;
      endcase
    end
  end

  // pipelined readback: lines driven one edge after the request, for one cycle
  always_ff @(posedge clk_sys or negedge master_reset_n) begin
    if (!master_reset_n) begin
      rb_q <= '0;
      rb_oe_q <= `MBA_OE_RST;
    end else if (!rst_n) begin
      rb_q <= '0;
      rb_oe_q <= `MBA_OE_RST;
    end else begin
      unique case (op)
        // R13: counter readback
        mba_pkg::MBA_OP_CNT_READ: begin
          rb_q <= cnt_q;
          rb_oe_q <= 1'h1;
        end
        // R14: mask readback
        mba_pkg::MBA_OP_MSK_READ: begin
          rb_q <= mask_q;
          rb_oe_q <= 1'h1;
        end
        default: begin
          rb_q <= rb_q;
          rb_oe_q <= 1'h0;
        end
      endcase
    end
  end

  // outputs straight from the registers; R8 tie-back relies on this timing
  assign addr_o = rb_q;
  assign addr_oe = rb_oe_q;
  assign count_addr = cnt_q;
  assign wrap_flag_n = wrap_q;

  // checks on the registers, both resets disable them
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n || !master_reset_n);

  sequence s_inc;
    op == mba_pkg::MBA_OP_CNT_INC;
  endsequence

  sequence s_inc_mid;
    s_inc ##0 !unmasked_full(cnt_q, mask_q);
  endsequence

  sequence s_inc_top;
    s_inc ##0 unmasked_full(cnt_q, mask_q);
  endsequence

  property p_masked_kept;
    s_inc_mid |=> (cnt_q & ~mask_q) == ($past(cnt_q) & ~$past(mask_q));
  endproperty
  a_masked_kept: assert property (p_masked_kept) // R1
    else $error("masked counter bits changed on increment");

  property p_step_size;
    s_inc_mid |=> (cnt_q & mask_q) == ((($past(cnt_q) & $past(mask_q))
      + ($past(mask_q[0]) ? ADDR_W'(1) : ADDR_W'(2))) & $past(mask_q));
  endproperty
  a_step_size: assert property (p_step_size) // R2
    else $error("increment step is wrong");

  property p_flag_low;
    s_inc ##1 unmasked_full(cnt_q, mask_q) |-> !wrap_flag_n;
  endproperty
  a_flag_low: assert property (p_flag_low) // R3
    else $error("wrap flag not low at top");

  property p_wrap_reload;
    s_inc_top |=> cnt_q == $past(mirror_q);
  endproperty
  a_wrap_reload: assert property (p_wrap_reload) // R4
    else $error("counter did not reload from mirror");

  property p_flag_high;
    s_inc ##1 !unmasked_full(cnt_q, mask_q) |-> wrap_flag_n;
  endproperty
  a_flag_high: assert property (p_flag_high) // R5
    else $error("wrap flag not released below top");

  property p_flag_release;
    (op inside {mba_pkg::MBA_OP_CNT_CLEAR, mba_pkg::MBA_OP_CNT_LOAD,
      mba_pkg::MBA_OP_MSK_CLEAR, mba_pkg::MBA_OP_MSK_LOAD}) |=> wrap_flag_n;
  endproperty
  a_flag_release: assert property (p_flag_release) // R6
    else $error("wrap flag not released by clear or load");

  property p_hold;
    op == mba_pkg::MBA_OP_CNT_HOLD |=> $stable(cnt_q) && $stable(mask_q) && $stable(mirror_q);
  endproperty
  a_hold: assert property (p_hold) // R7
    else $error("hold changed a register");

  property p_mirror_kept;
    s_inc |=> $stable(mirror_q);
  endproperty
  a_mirror_kept: assert property (p_mirror_kept) // R12
    else $error("mirror changed on increment");

  property p_readback;
    op == mba_pkg::MBA_OP_CNT_READ |=> addr_oe && addr_o == $past(cnt_q);
  endproperty
  a_readback: assert property (p_readback) // R13
    else $error("counter readback wrong");

  property p_mask_reset;
    op == mba_pkg::MBA_OP_MSK_CLEAR |=> mask_q == '1 && wrap_flag_n;
  endproperty
  a_mask_reset: assert property (p_mask_reset) // R14
    else $error("mask reset did not set all ones");

  property p_counter_clear;
    op == mba_pkg::MBA_OP_CNT_CLEAR |=> cnt_q == ($past(cnt_q) & ~$past(mask_q))
      && mirror_q == ($past(mirror_q) & ~$past(mask_q));
  endproperty
  a_counter_clear: assert property (p_counter_clear) // R15
    else $error("counter clear result wrong");

  property p_load;
    op == mba_pkg::MBA_OP_CNT_LOAD |=> cnt_q == $past(addr_i) && mirror_q == $past(addr_i);
  endproperty
  a_load: assert property (p_load) // R17
    else $error("counter load did not fill counter and mirror");

endmodule // mba_counter

// ---- bench/mba_ctl_model.sv ----
// Purpose: memory controller model driving the counter control lines
// Assumes: bench changes op and op_addr at the falling clock edge
// Notes: address lines carry an inverted value unless a load is requested
`timescale 1ns/1ps

module mba_ctl_model #(
  parameter int ADDR_W = 17
) (
  // requested operation
  input wire mba_pkg::mba_op_t op,
  input wire logic [ADDR_W-1:0] op_addr,
  input wire logic loop_zero,
  // feedback from the counter
  input wire logic wrap_flag_n,
  // control and address lines
  output mba_pkg::mba_ctrl_t ctrl,
  output logic [ADDR_W-1:0] addr_i
);
  logic [3:0] code; // select, clear_n, strobe_n, enable_n

  always_comb begin
    case (op)
      mba_pkg::MBA_OP_CNT_CLEAR: code = 4'hB;
      mba_pkg::MBA_OP_CNT_LOAD: code = 4'hC;
      mba_pkg::MBA_OP_CNT_READ: code = 4'hD;
      mba_pkg::MBA_OP_CNT_INC: code = 4'hE;
      mba_pkg::MBA_OP_MSK_CLEAR: code = 4'h3;
      mba_pkg::MBA_OP_MSK_LOAD: code = 4'h4;
      mba_pkg::MBA_OP_MSK_READ: code = 4'h5;
      mba_pkg::MBA_OP_RESERVED: code = 4'h6;
      default: code = 4'hF; // hold
    endcase
  end

  always_comb begin
    ctrl = code;
    if (loop_zero && code[3] && !wrap_flag_n) ctrl.counter_clear_n = 1'h0;
  end

  // inverse when not loading, so a stale value never passes for a good one
  assign addr_i = (code[2:0] == 3'h4) ? op_addr : ~op_addr;
endmodule // mba_ctl_model

// ---- bench/mba_counter_bench.sv ----
// Purpose: self-checking bench for the masked burst address counter
// Assumes: default address width of seventeen bits
// Notes: each op is presented at a falling edge, results read at the next
`timescale 1ns/1ps

module mba_counter_bench;
  localparam int AW = 17;
  logic clk_sys, rst_n, master_reset_n, loop_zero, addr_oe, wrap_flag_n;
  mba_pkg::mba_op_t op;
  mba_pkg::mba_ctrl_t ctrl;
  logic [AW-1:0] op_addr, addr_i, addr_o, count_addr;
  int errors, checked;

  mba_ctl_model #(.ADDR_W(AW)) mba_ctl_model_i (.op(op), .op_addr(op_addr),
    .loop_zero(loop_zero), .wrap_flag_n(wrap_flag_n), .ctrl(ctrl), .addr_i(addr_i));
  mba_counter #(.ADDR_W(AW)) mba_counter_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .master_reset_n(master_reset_n), .ctrl(ctrl), .addr_i(addr_i), .addr_o(addr_o),
    .addr_oe(addr_oe), .count_addr(count_addr), .wrap_flag_n(wrap_flag_n));

  // 25 MHz clock
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %0h wanted %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // present one op, return at the next falling edge with results settled
  task automatic step(input mba_pkg::mba_op_t o, input logic [AW-1:0] a);
    op = o;
    op_addr = a;
    @(negedge clk_sys);
  endtask

  task automatic t_reset();
    chk(count_addr, 0);
    chk(wrap_flag_n, 1);
    step(mba_pkg::MBA_OP_MSK_READ, 0);
    chk(addr_oe, 1);
    chk(addr_o, 17'h1FFFF);
    step(mba_pkg::MBA_OP_CNT_HOLD, 0);
    chk(addr_oe, 0);
  endtask

  // block of 6 bits above a fixed base, replayed twice
  task automatic t_block();
    step(mba_pkg::MBA_OP_MSK_LOAD, 17'h0003F);
    step(mba_pkg::MBA_OP_CNT_LOAD, 17'h10008);
    chk(count_addr, 17'h10008);
    for (int p = 0; p < 2; p++) begin
      for (int v = 9; v <= 63; v++) begin
        step(mba_pkg::MBA_OP_CNT_INC, 0);
        chk(count_addr, 17'h10000 + v);
        chk(wrap_flag_n, v != 63);
      end
      step(mba_pkg::MBA_OP_CNT_INC, 0);
      chk(count_addr, 17'h10008);
      chk(wrap_flag_n, 1);
    end
    step(mba_pkg::MBA_OP_CNT_READ, 0);
    chk(addr_o, 17'h10008);
  endtask

  task automatic t_by_two();
    step(mba_pkg::MBA_OP_MSK_LOAD, 17'h0003E);
    step(mba_pkg::MBA_OP_CNT_LOAD, 17'h10005);
    step(mba_pkg::MBA_OP_CNT_INC, 0);
    chk(count_addr, 17'h10007);
    step(mba_pkg::MBA_OP_CNT_CLEAR, 0);
    chk(count_addr, 17'h10001);
    for (int v = 3; v <= 63; v += 2) step(mba_pkg::MBA_OP_CNT_INC, 0);
    chk(wrap_flag_n, 0);
    step(mba_pkg::MBA_OP_CNT_INC, 0);
    chk(count_addr, 17'h10001);
    repeat (20) step(mba_pkg::MBA_OP_CNT_HOLD, 0);
    repeat (3) step(mba_pkg::MBA_OP_RESERVED, 0);
    chk(count_addr, 17'h10001);
    step(mba_pkg::MBA_OP_MSK_READ, 0);
    chk(addr_o, 17'h0003E);
  endtask

  // every clearing or loading op releases a low flag
  task automatic t_release();
    mba_pkg::mba_op_t ops[4];
    ops = '{mba_pkg::MBA_OP_CNT_CLEAR, mba_pkg::MBA_OP_CNT_LOAD,
            mba_pkg::MBA_OP_MSK_CLEAR, mba_pkg::MBA_OP_MSK_LOAD};
    foreach (ops[i]) begin
      step(mba_pkg::MBA_OP_MSK_LOAD, 17'h00003);
      step(mba_pkg::MBA_OP_CNT_LOAD, 17'h00002);
      step(mba_pkg::MBA_OP_CNT_INC, 0);
      chk(wrap_flag_n, 0);
      step(ops[i], 17'h00003);
      chk(wrap_flag_n, 1);
    end
  endtask

  // flag fed back into counter clear loops through zero
  task automatic t_loop();
    int exp[7];
    exp = '{2, 3, 0, 1, 2, 3, 0};
    step(mba_pkg::MBA_OP_MSK_LOAD, 17'h00003);
    step(mba_pkg::MBA_OP_CNT_LOAD, 17'h00001);
    loop_zero = 1'h1;
    foreach (exp[i]) begin
      step(mba_pkg::MBA_OP_CNT_INC, 0);
      chk(count_addr, exp[i]);
    end
    loop_zero = 1'h0;
  endtask

  task automatic t_full();
    step(mba_pkg::MBA_OP_MSK_CLEAR, 0);
    step(mba_pkg::MBA_OP_CNT_LOAD, 17'h1FFFE);
    step(mba_pkg::MBA_OP_CNT_INC, 0);
    chk(count_addr, 17'h1FFFF);
    chk(wrap_flag_n, 0);
    step(mba_pkg::MBA_OP_CNT_INC, 0);
    chk(count_addr, 17'h1FFFE);
    step(mba_pkg::MBA_OP_MSK_LOAD, 17'h0001E);
    step(mba_pkg::MBA_OP_CNT_HOLD, 0);
    // reload to an all-ones start leaves the flag low for the reset to release
    step(mba_pkg::MBA_OP_CNT_INC, 0);
    chk(count_addr, 17'h1FFFE);
    chk(wrap_flag_n, 0);
    // master reset acts between edges
    master_reset_n = 1'h0;
    #1;
    chk(count_addr, 0);
    chk(wrap_flag_n, 1);
    @(negedge clk_sys);
    master_reset_n = 1'h1;
    step(mba_pkg::MBA_OP_MSK_READ, 0);
    chk(addr_o, 17'h1FFFF);
    // a wrap after master reset shows the cleared mirror
    step(mba_pkg::MBA_OP_MSK_LOAD, 17'h00001);
    step(mba_pkg::MBA_OP_CNT_INC, 0);
    chk(count_addr, 17'h00001);
    step(mba_pkg::MBA_OP_CNT_INC, 0);
    chk(count_addr, 0);
  endtask

  initial begin
    rst_n = 1'h0;
    master_reset_n = 1'h1;
    loop_zero = 1'h0;
    op = mba_pkg::MBA_OP_CNT_HOLD;
    op_addr = '0;
    errors = 0;
    checked = 0;
    repeat (10) @(negedge clk_sys);
    rst_n = 1'h1;
    t_reset();
    t_block();
    t_by_two();
    t_release();
    t_loop();
    t_full();
    complete_run();
  end

  // watchdog: far beyond the few hundred cycles the tests take
  initial begin
    #200000;
    errors++;
    complete_run();
  end
endmodule // mba_counter_bench
